//--- hdl/charger_sequencer_status.sv
// Charge cycle sequencer, input regulator gating and open-drain status encoder.
// Assumes the analog comparator flags are clean and synchronous to mclk.
// Functional notes
// - Trickle start limits current to one tenth
// - Half hour below trickle gives bad battery
// - Above trickle switches to full current
// - Reaching float starts four hour timer
// - Timer expiry ends cycle, current off
// - Filtered recharge threshold restarts after termination
// - Recharge dip clears running safety timer
// - Recharge dip must outlast filter time
// - Lockout or enable cycling restarts everything
// - Status held low during normal charging
// - Status released at float and tenth current
// - Faults toggle carrier with alternating duty
// - Temperature fault: 6.25/93.75 percent, slow blink
// - Bad battery: 12.5/87.5 percent, fast blink
// - Tenth current ignored during input limit
// - Out-of-range temperature pauses charging
// - Pause in float freezes safety timer
// - Grounded thermistor disables temperature pause
// - Bus lockout hysteresis gates switching regulator
// - Suspend enables only the suspend regulator
`timescale 1ns/10ps
`default_nettype none

module charger_sequencer_status
	import charger_seq_pkg::*;
#(
	parameter logic [LONG_W-1:0] TRICKLE_TIMEOUT = LONG_W'(TRICKLE_TIMEOUT_CYCLES),
	parameter logic [LONG_W-1:0] SAFETY_TIMEOUT = LONG_W'(SAFETY_TIMER_CYCLES),
	parameter logic [FILT_W-1:0] RECHARGE_FILTER = FILT_W'(RECHARGE_FILTER_CYCLES),
	parameter logic [SLOT_W-1:0] SLOT_LEN = SLOT_W'(SLOT_CYCLES),
	parameter logic [BLINK_W-1:0] TEMP_HALF_BLINK = BLINK_W'(TEMP_HALF_BLINK_CYCLES),
	parameter logic [BLINK_W-1:0] BAD_HALF_BLINK = BLINK_W'(BAD_HALF_BLINK_CYCLES)
) (
	// Clock and reset.
	input wire logic mclk,
	input wire logic reset,
	// Host controls.
	input wire logic charger_on_input,
	input wire logic input_limit_sel0,
	input wire logic input_limit_sel1,
	// Bus comparators.
	input wire logic bus_rise_ok,
	input wire logic bus_fall_trip,
	input wire logic input_in_current_limit,
	// Battery comparators.
	input wire logic bat_below_trickle,
	input wire logic bat_at_float,
	input wire logic bat_below_recharge,
	input wire logic current_below_tenth,
	// Thermistor comparators.
	input wire logic thermistor_hot,
	input wire logic thermistor_cold,
	input wire logic thermistor_grounded,
	// Regulator and charger commands.
	output logic switcher_enable,
	output logic suspend_regulator_enable,
	output logic undervoltage_lockout,
	output logic [1:0] charge_current_cmd,
	// Open-drain status pin.
	input wire logic charge_status_out_i,
	output logic charge_status_out_o,
	output logic charge_status_out_oe
);
	import charger_seq_pkg::*;

	charge_state_t state;
	logic bus_ok;
	logic enabled;
	logic suspend;
	logic temp_fault;
	logic pause;
	logic [LONG_W-1:0] trickle_cnt;
	logic [LONG_W-1:0] safety_cnt;
	logic [FILT_W-1:0] filter_cnt;
	logic recharge_dip;
	logic tenth_seen;
	logic [SLOT_W-1:0] slot_cnt;
	logic [3:0] slot_idx;
	logic [BLINK_W-1:0] blink_cnt;
	logic blink_bright;
	logic [BLINK_W-1:0] half_blink;
	logic [4:0] duty_slots;
	logic next_status_low;

	// ---------------------------------------------------------------
	// Input regulator gating
	// ---------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (reset) begin
			bus_ok <= 1'b0;
		end else if (bus_fall_trip) begin
			bus_ok <= 1'b0;
		end else if (bus_rise_ok) begin
			bus_ok <= 1'b1;
		end
	end

	assign suspend = ({input_limit_sel1, input_limit_sel0} == LIMIT_SUSPEND);
	assign enabled = bus_ok && charger_on_input && !suspend;
	assign temp_fault = !thermistor_grounded && (thermistor_hot || thermistor_cold);
	assign pause = temp_fault;

	always_ff @(posedge mclk) begin
		if (reset) begin
			switcher_enable <= 1'b0;
			suspend_regulator_enable <= 1'b0;
			undervoltage_lockout <= 1'b1;
		end else begin
			switcher_enable <= bus_ok && !suspend;
			suspend_regulator_enable <= suspend;
			undervoltage_lockout <= !bus_ok;
		end
	end

	// ---------------------------------------------------------------
	// Recharge threshold filter
	// ---------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (reset || !bat_below_recharge) begin
			filter_cnt <= '0;
		end else if (filter_cnt != RECHARGE_FILTER) begin
			filter_cnt <= filter_cnt + 1'b1;
		end
	end

	assign recharge_dip = (filter_cnt == RECHARGE_FILTER);

	// ---------------------------------------------------------------
	// Charge cycle sequencer
	// ---------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (reset) begin
			state <= ST_IDLE;
		end else if (!enabled) begin
			state <= ST_IDLE;
		end else begin
			case (state)
				ST_IDLE: begin
					state <= bat_below_trickle ? ST_TRICKLE : ST_CONST_CURRENT;
				end
				ST_TRICKLE: begin
					if (!bat_below_trickle) begin
						state <= ST_CONST_CURRENT;
					end else if (trickle_cnt >= TRICKLE_TIMEOUT) begin
						state <= ST_BAD_BATTERY;
					end
				end
				ST_CONST_CURRENT: begin
					if (bat_at_float) begin
						state <= ST_FLOAT;
					end
				end
				ST_FLOAT: begin
					if (recharge_dip) begin
						state <= ST_CONST_CURRENT;
					end else if (safety_cnt >= SAFETY_TIMEOUT) begin
						state <= ST_DONE;
					end
				end
				ST_DONE: begin
					if (recharge_dip) begin
						state <= bat_below_trickle ? ST_TRICKLE : ST_CONST_CURRENT;
					end
				end
				ST_BAD_BATTERY: begin
					state <= ST_BAD_BATTERY;
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// Trickle time is counted only while actually charging.
	always_ff @(posedge mclk) begin
		if (reset || state != ST_TRICKLE) begin
			trickle_cnt <= '0;
		end else if (!pause && trickle_cnt < TRICKLE_TIMEOUT) begin
			trickle_cnt <= trickle_cnt + 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset || state != ST_FLOAT || recharge_dip) begin
			safety_cnt <= '0;
		end else if (!pause && safety_cnt < SAFETY_TIMEOUT) begin
			safety_cnt <= safety_cnt + 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset || state != ST_FLOAT) begin
			tenth_seen <= 1'b0;
		end else if (current_below_tenth && !input_in_current_limit) begin
			tenth_seen <= 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			charge_current_cmd <= CURRENT_OFF;
		end else if (pause) begin
			charge_current_cmd <= CURRENT_OFF;
		end else begin
			case (state)
				ST_TRICKLE: charge_current_cmd <= CURRENT_TENTH;
				ST_CONST_CURRENT: charge_current_cmd <= CURRENT_FULL;
				ST_FLOAT: charge_current_cmd <= CURRENT_FULL;
				default: charge_current_cmd <= CURRENT_OFF;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Status carrier and blink modulation
	// ---------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (reset || slot_cnt == SLOT_LEN - 1'b1) begin
			slot_cnt <= '0;
		end else begin
			slot_cnt <= slot_cnt + 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			slot_idx <= '0;
		end else if (slot_cnt == SLOT_LEN - 1'b1) begin
			slot_idx <= slot_idx + 1'b1;
		end
	end

	assign half_blink = (state == ST_BAD_BATTERY) ? BAD_HALF_BLINK : TEMP_HALF_BLINK;

	always_ff @(posedge mclk) begin
		if (reset || blink_cnt >= half_blink - 1'b1) begin
			blink_cnt <= '0;
		end else begin
			blink_cnt <= blink_cnt + 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			blink_bright <= 1'b0;
		end else if (blink_cnt >= half_blink - 1'b1) begin
			blink_bright <= !blink_bright;
		end
	end

	always_comb begin
		if (state == ST_BAD_BATTERY) begin
			duty_slots = blink_bright ? BAD_DUTY_BRIGHT : BAD_DUTY_DIM;
		end else begin
			duty_slots = blink_bright ? TEMP_DUTY_BRIGHT : TEMP_DUTY_DIM;
		end
	end

	always_comb begin
		case (state)
			ST_BAD_BATTERY: next_status_low = ({1'b0, slot_idx} < duty_slots);
			ST_TRICKLE, ST_CONST_CURRENT, ST_FLOAT: begin
				if (temp_fault) begin
					next_status_low = ({1'b0, slot_idx} < duty_slots);
				end else begin
					next_status_low = (state != ST_FLOAT) || !tenth_seen;
				end
			end
			default: next_status_low = 1'b0;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			charge_status_out_oe <= 1'b0;
		end else begin
			charge_status_out_oe <= next_status_low;
		end
	end

	assign charge_status_out_o = 1'b0;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	AST_TRICKLE_TENTH: assert property (@(posedge mclk) disable iff (reset)
		(state == ST_TRICKLE && !pause && enabled) |=> (charge_current_cmd == CURRENT_TENTH))
		else $error("trickle current not one tenth");

	AST_BAD_AFTER_TIMEOUT: assert property (@(posedge mclk) disable iff (reset)
		(state == ST_TRICKLE && enabled && bat_below_trickle && trickle_cnt >= TRICKLE_TIMEOUT)
		|=> (state == ST_BAD_BATTERY))
		else $error("bad battery not flagged at trickle timeout");

	AST_LEAVE_TRICKLE: assert property (@(posedge mclk) disable iff (reset)
		(state == ST_TRICKLE && enabled && !bat_below_trickle) |=> (state == ST_CONST_CURRENT) ##1
		($past(pause) || charge_current_cmd == CURRENT_FULL || state != ST_CONST_CURRENT))
		else $error("no full current after trickle");

	AST_TIMER_RUNS: assert property (@(posedge mclk) disable iff (reset)
		(state == ST_FLOAT && $past(state) == ST_FLOAT && !$past(pause) && !$past(recharge_dip)
		&& $past(safety_cnt) < SAFETY_TIMEOUT) |-> (safety_cnt == $past(safety_cnt) + 1'b1))
		else $error("safety timer not counting in float");

	AST_EXPIRY_STOPS: assert property (@(posedge mclk) disable iff (reset)
		(state == ST_FLOAT && enabled && !recharge_dip && safety_cnt >= SAFETY_TIMEOUT)
		|=> (state == ST_DONE) ##1 (charge_current_cmd == CURRENT_OFF))
		else $error("charge not ended at timer expiry");

	AST_RECHARGE: assert property (@(posedge mclk) disable iff (reset)
		(state == ST_DONE && enabled && recharge_dip) |=> (state == ST_TRICKLE || state == ST_CONST_CURRENT))
		else $error("no automatic recharge");

	AST_FILTER_TIME: assert property (@(posedge mclk) disable iff (reset)
		$rose(recharge_dip) |-> ($past(bat_below_recharge) && $past(filter_cnt) == RECHARGE_FILTER - 1'b1))
		else $error("recharge acted before filter time");

	AST_DISABLE_IDLE: assert property (@(posedge mclk) disable iff (reset)
		!enabled |=> (state == ST_IDLE) ##1 (charge_current_cmd == CURRENT_OFF))
		else $error("disable did not restart cycle");

	AST_FREEZE: assert property (@(posedge mclk) disable iff (reset)
		(state == ST_FLOAT && $past(state) == ST_FLOAT && $past(pause) && !$past(recharge_dip))
		|-> $stable(safety_cnt))
		else $error("safety timer moved during pause");

	AST_PAUSE_OFF: assert property (@(posedge mclk) disable iff (reset)
		(thermistor_hot && !thermistor_grounded) |=> (charge_current_cmd == CURRENT_OFF))
		else $error("charge not paused on hot battery");

	AST_SUSPEND: assert property (@(posedge mclk) disable iff (reset)
		suspend |=> (!switcher_enable && suspend_regulator_enable))
		else $error("suspend regulators wrong");

	AST_LOCKOUT: assert property (@(posedge mclk) disable iff (reset)
		bus_fall_trip |-> ##2 !switcher_enable)
		else $error("switcher on below falling threshold");

	AST_CHARGING_LOW: assert property (@(posedge mclk) disable iff (reset)
		(state == ST_CONST_CURRENT && !temp_fault) |=> charge_status_out_oe)
		else $error("status not low while charging");

	COVER_BAD: cover property (@(posedge mclk) disable iff (reset)
		state == ST_TRICKLE ##1 state == ST_BAD_BATTERY);
	COVER_DONE: cover property (@(posedge mclk) disable iff (reset)
		state == ST_FLOAT ##1 state == ST_DONE);
	COVER_RESTART: cover property (@(posedge mclk) disable iff (reset)
		state == ST_DONE ##1 state == ST_CONST_CURRENT);
	COVER_TEMP_BLINK: cover property (@(posedge mclk) disable iff (reset)
		temp_fault && state == ST_FLOAT && $rose(blink_bright));

endmodule

`default_nettype wire

//--- hdl/charger_seq_pkg.sv
// Constants shared by the charger sequencer: clock rate, timings and status codes.
// Assumes a single 200 MHz system clock drives all sequencer logic.
package charger_seq_pkg;

	// ---------------------------------------------------------------
	// Clock and time figures
	// ---------------------------------------------------------------
	localparam longint unsigned CLK_HZ = 200_000_000;
	localparam longint unsigned NS_PER_S = 1_000_000_000;
	localparam longint unsigned TRICKLE_TIMEOUT_S = 1_800;
	localparam longint unsigned SAFETY_TIMER_S = 14_400;
	localparam longint unsigned RECHARGE_FILTER_NS = 1_300_000;
	localparam longint unsigned CARRIER_HZ = 35_000;
	localparam longint unsigned TEMP_BLINK_MHZ = 1_500;
	localparam longint unsigned BAD_BLINK_MHZ = 6_100;

	// ---------------------------------------------------------------
	// Widths and derived cycle counts
	// ---------------------------------------------------------------
	localparam int LONG_W = 42;
	localparam int FILT_W = 19;
	localparam int BLINK_W = 27;
	localparam int SLOT_W = 9;
	localparam int SLOTS_PER_PERIOD = 16;

	localparam longint unsigned TRICKLE_TIMEOUT_CYCLES = TRICKLE_TIMEOUT_S * CLK_HZ;
	localparam longint unsigned SAFETY_TIMER_CYCLES = SAFETY_TIMER_S * CLK_HZ;
	localparam longint unsigned RECHARGE_FILTER_CYCLES = (RECHARGE_FILTER_NS * CLK_HZ + NS_PER_S - 1) / NS_PER_S;
	localparam longint unsigned SLOT_CYCLES = CLK_HZ / (CARRIER_HZ * SLOTS_PER_PERIOD);
	localparam longint unsigned TEMP_HALF_BLINK_CYCLES = (CLK_HZ * 1000) / (TEMP_BLINK_MHZ * 2);
	localparam longint unsigned BAD_HALF_BLINK_CYCLES = (CLK_HZ * 1000) / (BAD_BLINK_MHZ * 2);

	// ---------------------------------------------------------------
	// Duty cycles as slots of sixteen held low
	// ---------------------------------------------------------------
	localparam logic [4:0] TEMP_DUTY_DIM = 5'h01;
	localparam logic [4:0] TEMP_DUTY_BRIGHT = 5'h0F;
	localparam logic [4:0] BAD_DUTY_DIM = 5'h02;
	localparam logic [4:0] BAD_DUTY_BRIGHT = 5'h0E;

	// ---------------------------------------------------------------
	// Input limit selections and charge current levels
	// ---------------------------------------------------------------
	localparam logic [1:0] LIMIT_USB_LOW = 2'h0;
	localparam logic [1:0] LIMIT_WALL = 2'h1;
	localparam logic [1:0] LIMIT_SUSPEND = 2'h2;
	localparam logic [1:0] LIMIT_USB_HIGH = 2'h3;

	localparam logic [1:0] CURRENT_OFF = 2'h0;
	localparam logic [1:0] CURRENT_TENTH = 2'h1;
	localparam logic [1:0] CURRENT_FULL = 2'h2;

	typedef enum {
		ST_IDLE,
		ST_TRICKLE,
		ST_CONST_CURRENT,
		ST_FLOAT,
		ST_DONE,
		ST_BAD_BATTERY
	} charge_state_t;

endpackage

//--- verif/status_reader.sv
// Model of a host that watches the open-drain status pin through a pull-up.
// Assumes it shares mclk with the sequencer and is reset with it.
`timescale 1ns/10ps
`default_nettype none

module status_reader (
	// Clock and reset.
	input wire logic mclk,
	input wire logic reset,
	// Pin and measurements.
	input wire logic pin_oe,
	output logic pin_level,
	output logic [15:0] low_run,
	output logic run_done,
	output logic reading_ok
);
	logic [15:0] cnt;
	logic [15:0] high_run;
	logic prev;

	// ---------------------------------------------------------------
	// Pin level and run measurement
	// ---------------------------------------------------------------
	// The pull-up holds the pin high whenever the sequencer lets go.
	assign pin_level = pin_oe ? 1'b0 : 1'b1;

	always_ff @(posedge mclk) begin
		if (reset) begin
			cnt <= 16'h0001;
			prev <= 1'b1;
			low_run <= 16'h0000;
			high_run <= 16'h0000;
			run_done <= 1'b0;
			reading_ok <= 1'b0;
		end else begin
			prev <= pin_level;
			run_done <= 1'b0;
			if (pin_level == prev) begin
				cnt <= (cnt == 16'hFFFF) ? cnt : cnt + 16'h0001;
			end else begin
				cnt <= 16'h0001;
				if (pin_level) begin
					low_run <= cnt;
					run_done <= 1'b1;
					// An exact half duty reading is thrown away.
					reading_ok <= (cnt != high_run);
				end else begin
					high_run <= cnt;
				end
			end
		end
	end
endmodule

`default_nettype wire

//--- verif/tb_top.sv
// Self-checking bench for the charger sequencer with a status pin reader.
// Assumes shortened timer parameters; inputs change on the falling edge.
`timescale 1ns/10ps
`default_nettype none

module tb_top;
	import charger_seq_pkg::*;
	localparam int SLOT = int'(SLOT_CYCLES);
	logic mclk = 1'b0, reset = 1'b1;
	logic charger_on_input = 1'b0, input_limit_sel0 = 1'b0, input_limit_sel1 = 1'b0;
	logic bus_rise_ok = 1'b0, bus_fall_trip = 1'b0, input_in_current_limit = 1'b0;
	logic bat_below_trickle = 1'b0, bat_at_float = 1'b0, bat_below_recharge = 1'b0;
	logic current_below_tenth = 1'b0, thermistor_hot = 1'b0, thermistor_cold = 1'b0;
	logic thermistor_grounded = 1'b0;
	logic switcher_enable, suspend_regulator_enable, undervoltage_lockout;
	logic [1:0] charge_current_cmd;
	logic pin_level, pin_o, pin_oe, run_done, reading_ok;
	logic [15:0] low_run;
	int failures = 0;
	int tests_run = 0;

	always #2.5 mclk = ~mclk;

	charger_sequencer_status #(.TRICKLE_TIMEOUT(42'h0C8), .SAFETY_TIMEOUT(42'h12C),
		.RECHARGE_FILTER(19'h014), .TEMP_HALF_BLINK(27'h4650),
		.BAD_HALF_BLINK(27'h3A98)) uut (.mclk(mclk), .reset(reset),
		.charger_on_input(charger_on_input), .input_limit_sel0(input_limit_sel0),
		.input_limit_sel1(input_limit_sel1), .bus_rise_ok(bus_rise_ok),
		.bus_fall_trip(bus_fall_trip), .input_in_current_limit(input_in_current_limit),
		.bat_below_trickle(bat_below_trickle), .bat_at_float(bat_at_float),
		.bat_below_recharge(bat_below_recharge), .current_below_tenth(current_below_tenth),
		.thermistor_hot(thermistor_hot), .thermistor_cold(thermistor_cold),
		.thermistor_grounded(thermistor_grounded), .switcher_enable(switcher_enable),
		.suspend_regulator_enable(suspend_regulator_enable),
		.undervoltage_lockout(undervoltage_lockout), .charge_current_cmd(charge_current_cmd),
		.charge_status_out_i(pin_level), .charge_status_out_o(pin_o),
		.charge_status_out_oe(pin_oe));

	status_reader host (.mclk(mclk), .reset(reset), .pin_oe(pin_oe), .pin_level(pin_level),
		.low_run(low_run), .run_done(run_done), .reading_ok(reading_ok));

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	task automatic chk_cmd(input logic [1:0] exp);
		chk("charge_current_cmd", {14'h0000, exp}, {14'h0000, charge_current_cmd});
	endtask

	task automatic chk_b(input string what, input logic exp, input logic got);
		chk(what, {15'h0000, exp}, {15'h0000, got});
	endtask

	// Waits for a completed low run of the given length with a valid reading.
	task automatic wait_run(input logic [15:0] exp);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < 40000 && !hit; i++) begin
			@(negedge mclk);
			if (run_done === 1'b1 && low_run === exp && reading_ok === 1'b1) hit = 1'b1;
		end
		chk("low_run", exp, hit ? exp : low_run);
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	initial begin
		repeat (80000) @(posedge mclk);
		failures++;
		summarize();
	end

	// ---------------------------------------------------------------
	// Tests
	// ---------------------------------------------------------------
	initial begin
		cyc(3);
		reset = 1'b0;
		chk_cmd(CURRENT_OFF);
		chk_b("lockout", 1'b1, undervoltage_lockout);
		bus_rise_ok = 1'b1;
		charger_on_input = 1'b1;
		cyc(5);
		chk_cmd(CURRENT_FULL);
		chk_b("oe", 1'b1, pin_oe);
		chk_b("pin_o", 1'b0, pin_o);
		chk_b("switcher", 1'b1, switcher_enable);
		chk_b("lockout", 1'b0, undervoltage_lockout);
		$display("test bring up done");
		for (int m = 0; m < 4; m++) begin
			{input_limit_sel1, input_limit_sel0} = 2'(m);
			cyc(4);
			chk_b("suspend", 2'(m) == LIMIT_SUSPEND, suspend_regulator_enable);
			chk_b("switcher", 2'(m) != LIMIT_SUSPEND, switcher_enable);
		end
		cyc(5);
		chk_cmd(CURRENT_FULL);
		$display("test input modes done");
		bat_at_float = 1'b1;
		input_in_current_limit = 1'b1;
		current_below_tenth = 1'b1;
		cyc(10);
		chk_b("oe", 1'b1, pin_oe);
		input_in_current_limit = 1'b0;
		cyc(4);
		chk_b("oe", 1'b0, pin_oe);
		cyc(260);
		chk_cmd(CURRENT_FULL);
		cyc(40);
		chk_cmd(CURRENT_OFF);
		$display("test termination done");
		bat_at_float = 1'b0;
		current_below_tenth = 1'b0;
		bat_below_recharge = 1'b1;
		cyc(10);
		bat_below_recharge = 1'b0;
		cyc(5);
		chk_cmd(CURRENT_OFF);
		bat_below_recharge = 1'b1;
		cyc(30);
		bat_below_recharge = 1'b0;
		cyc(4);
		chk_cmd(CURRENT_FULL);
		bat_at_float = 1'b1;
		cyc(200);
		bat_at_float = 1'b0;
		bat_below_recharge = 1'b1;
		cyc(30);
		bat_below_recharge = 1'b0;
		bat_at_float = 1'b1;
		cyc(200);
		chk_cmd(CURRENT_FULL);
		$display("test recharge done");
		thermistor_hot = 1'b1;
		cyc(10);
		chk_cmd(CURRENT_OFF);
		wait_run(16'(SLOT * TEMP_DUTY_DIM));
		wait_run(16'(SLOT * TEMP_DUTY_BRIGHT));
		thermistor_hot = 1'b0;
		cyc(10);
		chk_cmd(CURRENT_FULL);
		cyc(50);
		chk_cmd(CURRENT_FULL);
		cyc(60);
		chk_cmd(CURRENT_OFF);
		$display("test temperature pause done");
		charger_on_input = 1'b0;
		bat_at_float = 1'b0;
		cyc(4);
		charger_on_input = 1'b1;
		cyc(5);
		chk_cmd(CURRENT_FULL);
		thermistor_cold = 1'b1;
		cyc(5);
		chk_cmd(CURRENT_OFF);
		thermistor_grounded = 1'b1;
		cyc(5);
		chk_cmd(CURRENT_FULL);
		thermistor_cold = 1'b0;
		thermistor_grounded = 1'b0;
		$display("test thermistor done");
		charger_on_input = 1'b0;
		bat_below_trickle = 1'b1;
		cyc(3);
		charger_on_input = 1'b1;
		cyc(5);
		chk_cmd(CURRENT_TENTH);
		cyc(220);
		chk_cmd(CURRENT_OFF);
		wait_run(16'(SLOT * BAD_DUTY_DIM));
		wait_run(16'(SLOT * BAD_DUTY_BRIGHT));
		$display("test bad battery done");
		bat_below_trickle = 1'b0;
		bus_fall_trip = 1'b1;
		cyc(4);
		chk_b("switcher", 1'b0, switcher_enable);
		chk_b("lockout", 1'b1, undervoltage_lockout);
		bus_fall_trip = 1'b0;
		cyc(6);
		chk_cmd(CURRENT_FULL);
		$display("test lockout done");
		summarize();
	end
endmodule

`default_nettype wire
